/* File: pkg/bdc_params.svh */
`ifndef BDC_PARAMS_SVH
`define BDC_PARAMS_SVH

// register offsets
`define BDC_OFS_MODE_CONTROL 8'h00
`define BDC_OFS_THRESHOLD_LEVEL 8'h01
`define BDC_OFS_MONITOR_LEVEL_CONTROL 8'h08
`define BDC_OFS_INTERRUPT_CONTROL 8'h09
`define BDC_OFS_INTERRUPT_FLAGS 8'h0a
`define BDC_OFS_MONITOR_STATUS 8'h0b

// field positions
`define BDC_POS_SLEEP_MODE 0
`define BDC_POS_ACTIVE_MODE 2
`define BDC_POS_SAMPLE_RATE 4
`define BDC_POS_THRESHOLD 0
`define BDC_POS_MON_OFFSET 0
`define BDC_POS_MON_IE 0
`define BDC_POS_MON_TRIG 1
`define BDC_POS_MON_FLAG 0
`define BDC_POS_MON_BELOW 0

// reset values and codes
`define BDC_RST_BYTE 8'h00
`define BDC_RATE_1K 1'h0
`define BDC_RATE_125 1'h1
`define BDC_TRIG_FALL 2'h0
`define BDC_TRIG_RISE 2'h1
`define BDC_TRIG_BOTH 2'h2

// timing
`define BDC_CLK_PERIOD_PS 5000
`define BDC_SAMPLE_1K_US 1000
`define BDC_CYC_1K (`BDC_SAMPLE_1K_US * 1000000 / `BDC_CLK_PERIOD_PS)
`define BDC_DIV_125 8
`define BDC_PROT_WINDOW 4

`endif

/* File: pkg/bdc_pkg.sv */
package bdc_pkg;

   typedef enum logic [1:0] {
      BDC_MODE_OFF,
      BDC_MODE_CONT,
      BDC_MODE_SAMPLED,
      BDC_MODE_CONT_STALL
   } bdc_mode_t;

   typedef struct packed {
      logic [1:0] active_mode;
      logic [1:0] sleep_mode;
      logic sample_rate;
      logic [2:0] threshold;
   } bdc_fuse_t;

   typedef struct packed {
      logic det_on;
      logic det_continuous;
      logic sample_strobe;
      logic [2:0] reset_threshold_select;
      logic [1:0] monitor_offset_select;
   } bdc_analog_t;

   typedef struct packed {
      logic loaded;
      bdc_mode_t active_mode;
      logic [1:0] sleep_mode;
      logic sample_rate_select;
      logic [2:0] reset_threshold_select;
      logic [1:0] monitor_offset_select;
      logic [1:0] monitor_trigger_select;
      logic monitor_irq_enable;
      logic monitor_irq_flag;
      logic monitor_below_status;
      logic prev_sampled;
      logic [2:0] key_cnt;
      logic [7:0] rdata;
      bdc_analog_t ana;
   } bdc_state_t;

endpackage

/* File: sim/bdc_ctrl_test.sv */
`timescale 1ns/1ps
`include "bdc_params.svh"

module bdc_ctrl_test
   import bdc_pkg::*;
;
   localparam int P1K = 16;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   bdc_fuse_t fuse = 8'h00;
   logic prot_key_written = 1'b0;
   logic deep_sleep = 1'b0;
   logic det_ready = 1'b0;
   logic mon_below_in = 1'b0;
   bdc_analog_t ana;
   logic wake_hold;
   logic monitor_irq;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h0000_004e;
   logic [7:0] got;

   always #2.5 clk = ~clk;

   bdc_ctrl #(.PERIOD_1K(P1K), .PROT_WINDOW(`BDC_PROT_WINDOW)) u_bdc_ctrl (
      .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .detector_config_fuse(fuse), .prot_key_written(prot_key_written),
      .deep_sleep(deep_sleep), .det_ready(det_ready), .mon_below_in(mon_below_in),
      .analog_ctrl(ana), .wake_hold(wake_hold), .monitor_irq(monitor_irq)
   );

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // mode_control image of a fuse byte: rate at 4, active at 3:2, sleep at 1:0
   function automatic logic [7:0] reg0_exp(input bdc_fuse_t f);
      return {3'h0, f.sample_rate, f.active_mode, f.sleep_mode};
   endfunction

   // {det_on, det_continuous}; reserved sleep code acts as off
   function automatic logic [7:0] mode_exp(input logic [1:0] m, input logic slp);
      return (slp && m == 2'h3) ? 8'h00 : {6'h00, |m, m[0]};
   endfunction

   // below 0->1 is a fall through the threshold
   function automatic logic hit(input logic [1:0] t, input logic was, input logic now);
      return (was != now) && ((t == `BDC_TRIG_FALL && now) ||
             (t == `BDC_TRIG_RISE && !now) || t == `BDC_TRIG_BOTH);
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 got = reg_rdata;
      chk(what, exp, got);
   endtask

   // gap adds idle cycles to the one that always stands between key pulse and write strobe
   task automatic keyed(input int gap, input logic [7:0] d);
      @(posedge clk);
      prot_key_written <= 1'b1;
      @(posedge clk);
      prot_key_written <= 1'b0;
      repeat (gap) @(posedge clk);
      wr(`BDC_OFS_MODE_CONTROL, d);
   endtask

   task automatic sleep_set(input logic v);
      @(posedge clk);
      deep_sleep <= v;
      step(3);
   endtask

   task automatic next_strobe(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (ana.sample_strobe !== 1'b1 && n < 400);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("ERROR timeout expected done seen hang");
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0] acts [4];
      logic [7:0] zaddr [5];
      logic was;
      logic fl;
      int n1;
      int n2;
      acts = '{2'h0, 2'h2, 2'h3, 2'h1};
      zaddr = '{8'h05, 8'h08, 8'h09, 8'h0a, 8'h0b};
      // fuse capture for every active mode, last one continuous
      for (int a = 0; a < 4; a++) begin
         @(posedge clk);
         rst_b <= 1'b0;
         seed = xs(seed);
         fuse <= {acts[a], seed[5:0]};
         det_ready <= 1'b0;
         repeat (20) @(posedge clk);
         rst_b <= 1'b1;
         step(3);
         rdchk("mode_control", 8'h00, reg0_exp(fuse));
         rdchk("threshold_level", 8'h01, {5'h00, fuse.threshold});
         chk("threshold pins", {5'h00, fuse.threshold}, {5'h00, ana.reset_threshold_select});
         chk("detector mode", mode_exp(acts[a], 1'b0), {6'h00, ana.det_on, ana.det_continuous});
         chk("wake_hold", {7'h00, acts[a] == 2'h3}, {7'h00, wake_hold});
         @(posedge clk);
         det_ready <= 1'b1;
         step(1);
         chk("wake_hold ready", 8'h00, {7'h00, wake_hold});
      end
      for (int i = 0; i < 5; i++) begin
         rdchk("reset value", zaddr[i], 8'h00);
      end
      wr(8'h01, 8'hff);
      rdchk("threshold_level write", 8'h01, {5'h00, fuse.threshold});
      $display("test fuse_load done");
      // protection window edges, active field never writable
      wr(8'h00, 8'h1d);
      rdchk("unkeyed write", 8'h00, reg0_exp(fuse));
      keyed(3, 8'h1d);
      rdchk("late keyed write", 8'h00, reg0_exp(fuse));
      keyed(2, 8'h1d);
      rdchk("keyed write", 8'h00, 8'h15);
      $display("test protection done");
      // every sleep code through a deep sleep round trip
      for (int s = 0; s < 4; s++) begin
         keyed(0, {6'h00, s[1:0]});
         rdchk("sleep field", 8'h00, {4'h0, 2'h1, s[1:0]});
         sleep_set(1'b1);
         chk("sleep mode", mode_exp(s[1:0], 1'b1), {6'h00, ana.det_on, ana.det_continuous});
         sleep_set(1'b0);
         chk("wake mode", 8'h03, {6'h00, ana.det_on, ana.det_continuous});
      end
      $display("test sleep_modes done");
      // sampled sleep at both rates: first sample early (checked at 1K only), then full periods
      for (int r = 0; r < 2; r++) begin
         keyed(1, {3'h0, r[0], 4'h2});
         sleep_set(1'b1);
         next_strobe(n1);
         next_strobe(n2);
         if (r == 0) begin
            chk("first sample", 8'h01, {7'h00, n1 + 3 <= P1K / 2 + 4});
         end
         chk("sample period", (r == 1) ? 8'(P1K * `BDC_DIV_125) : 8'(P1K), n2[7:0]);
         sleep_set(1'b0);
      end
      $display("test sampling done");
      // every trigger code against random supply moves
      for (int t = 0; t < 4; t++) begin
         wr(8'h09, {5'h00, t[1:0], 1'b1});
         wr(8'h0a, 8'h01);
         fl = 1'b0;
         rdchk("interrupt_control", 8'h09, {5'h00, t[1:0], 1'b1});
         for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            was = mon_below_in;
            @(posedge clk);
            mon_below_in <= seed[3];
            step(2);
            fl |= hit(t[1:0], was, seed[3]);
            chk("monitor_irq", {7'h00, fl}, {7'h00, monitor_irq});
            rdchk("monitor_status", 8'h0b, {7'h00, seed[3]});
            if (seed[9]) begin
               wr(8'h0a, {7'h00, seed[10]});
               fl = fl & ~seed[10];
            end
         end
         wr(8'h09, {5'h00, t[1:0], 1'b0});
         step(1);
         chk("masked irq", 8'h00, {7'h00, monitor_irq});
         rdchk("interrupt_flags", 8'h0a, {7'h00, fl});
      end
      for (int o = 0; o < 4; o++) begin
         seed = xs(seed);
         wr(8'h08, seed[7:0]);
         rdchk("monitor_level_control", 8'h08, {6'h00, seed[1:0]});
         chk("offset pins", {6'h00, seed[1:0]}, {6'h00, ana.monitor_offset_select});
      end
      $display("test monitor done");
      // flag and status die with the detector
      wr(8'h09, 8'h05);
      @(posedge clk);
      mon_below_in <= 1'b0;
      step(2);
      @(posedge clk);
      mon_below_in <= 1'b1;
      step(2);
      chk("flag raised", 8'h01, {7'h00, monitor_irq});
      keyed(1, 8'h00);
      sleep_set(1'b1);
      chk("flag while off", 8'h00, {7'h00, monitor_irq});
      rdchk("status while off", 8'h0b, 8'h00);
      sleep_set(1'b0);
      $display("test detector_off done");
      print_verdict();
   end
endmodule

/* File: verilog/bdc_ctrl.sv */
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "bdc_params.svh"

module bdc_ctrl
   import bdc_pkg::*;
#(
   parameter int PERIOD_1K = `BDC_CYC_1K,
   parameter int PROT_WINDOW = `BDC_PROT_WINDOW
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire bdc_fuse_t detector_config_fuse,
   input wire logic prot_key_written,
   input wire logic deep_sleep,
   input wire logic det_ready,
   input wire logic mon_below_in,
   output bdc_analog_t analog_ctrl,
   output logic wake_hold,
   output logic monitor_irq
);
   // refused at elaboration: the key counter is three bits wide
   if (PROT_WINDOW < 1 || PROT_WINDOW > 7) begin : g_bad_window
      $error("bdc_ctrl: protection window must be 1 to 7");
   end

   bdc_state_t s_reg;
   bdc_state_t s_next;
   logic tick;
   logic restart;
   bdc_mode_t eff_mode;
   logic det_on;
   logic sampled;

   function automatic bdc_mode_t sleep_to_mode(input logic [1:0] code);
      // reserved code behaves as disabled
      if (code == 2'h3) begin
         return BDC_MODE_OFF;
      end
      return bdc_mode_t'(code);
   endfunction

   function automatic logic crossing_hit(input logic [1:0] trig, input logic was,
                                         input logic now);
      logic fall;
      logic rise;
      fall = !was && now;
      rise = was && !now;
      case (trig)
         `BDC_TRIG_FALL: crossing_hit = fall;
         `BDC_TRIG_RISE: crossing_hit = rise;
         `BDC_TRIG_BOTH: crossing_hit = fall || rise;
         default: crossing_hit = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   bdc_sample_timer #(
      .PERIOD_1K(PERIOD_1K),
      .DIV_125(`BDC_DIV_125)
   ) u_timer (
      .clk(clk),
      .rst_b(rst_b),
      .restart(restart),
      .rate_125(s_reg.sample_rate_select),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      eff_mode = deep_sleep ? sleep_to_mode(s_reg.sleep_mode) : s_reg.active_mode;
      if (!s_reg.loaded) begin
         eff_mode = BDC_MODE_OFF;
      end
      det_on = (eff_mode != BDC_MODE_OFF);
      sampled = (eff_mode == BDC_MODE_SAMPLED);
      restart = sampled && !s_reg.prev_sampled;
   end

   always_comb begin
      logic upd;
      logic hit;
      upd = 1'b0;
      hit = 1'b0;
      s_next = s_reg;
      s_next.rdata = `BDC_RST_BYTE;
      s_next.prev_sampled = sampled;
      if (!s_reg.loaded) begin
         // fuses are caught in the first clocked cycle after release
         s_next.loaded = 1'b1;
         s_next.active_mode = bdc_mode_t'(detector_config_fuse.active_mode);
         s_next.sleep_mode = detector_config_fuse.sleep_mode;
         s_next.sample_rate_select = detector_config_fuse.sample_rate;
         s_next.reset_threshold_select = detector_config_fuse.threshold;
      end
      if (prot_key_written) begin
         s_next.key_cnt = 3'(PROT_WINDOW);
      end else if (s_reg.key_cnt != 3'h0) begin
         s_next.key_cnt = s_reg.key_cnt - 3'h1;
      end
      if (reg_wr && s_reg.loaded) begin
         case (reg_addr)
            `BDC_OFS_MODE_CONTROL: begin
               // active mode bits never taken from the bus
               if (s_reg.key_cnt != 3'h0) begin
                  s_next.sleep_mode = reg_wdata[`BDC_POS_SLEEP_MODE +: 2];
                  s_next.sample_rate_select = reg_wdata[`BDC_POS_SAMPLE_RATE];
                  s_next.key_cnt = 3'h0;
               end
            end
            `BDC_OFS_MONITOR_LEVEL_CONTROL: begin
               s_next.monitor_offset_select = reg_wdata[`BDC_POS_MON_OFFSET +: 2];
            end
            `BDC_OFS_INTERRUPT_CONTROL: begin
               s_next.monitor_irq_enable = reg_wdata[`BDC_POS_MON_IE];
               s_next.monitor_trigger_select = reg_wdata[`BDC_POS_MON_TRIG +: 2];
            end
            `BDC_OFS_INTERRUPT_FLAGS: begin
               if (reg_wdata[`BDC_POS_MON_FLAG]) begin
                  s_next.monitor_irq_flag = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      // monitor only looks when the detector does, at its sample rate
      upd = det_on && (!sampled || tick);
      if (upd) begin
         hit = crossing_hit(s_reg.monitor_trigger_select, s_reg.monitor_below_status,
                            mon_below_in);
         s_next.monitor_below_status = mon_below_in;
      end
      if (hit) begin
         s_next.monitor_irq_flag = 1'b1;
      end
      if (!det_on) begin
         s_next.monitor_irq_flag = 1'b0;
         s_next.monitor_below_status = 1'b0;
      end
      if (reg_rd) begin
         case (reg_addr)
            `BDC_OFS_MODE_CONTROL: begin
               s_next.rdata[`BDC_POS_SLEEP_MODE +: 2] = s_reg.sleep_mode;
               s_next.rdata[`BDC_POS_ACTIVE_MODE +: 2] = s_reg.active_mode;
               s_next.rdata[`BDC_POS_SAMPLE_RATE] = s_reg.sample_rate_select;
            end
            `BDC_OFS_THRESHOLD_LEVEL: begin
               s_next.rdata[`BDC_POS_THRESHOLD +: 3] = s_reg.reset_threshold_select;
            end
            `BDC_OFS_MONITOR_LEVEL_CONTROL: begin
               s_next.rdata[`BDC_POS_MON_OFFSET +: 2] = s_reg.monitor_offset_select;
            end
            `BDC_OFS_INTERRUPT_CONTROL: begin
               s_next.rdata[`BDC_POS_MON_IE] = s_reg.monitor_irq_enable;
               s_next.rdata[`BDC_POS_MON_TRIG +: 2] = s_reg.monitor_trigger_select;
            end
            `BDC_OFS_INTERRUPT_FLAGS: begin
               s_next.rdata[`BDC_POS_MON_FLAG] = s_reg.monitor_irq_flag;
            end
            `BDC_OFS_MONITOR_STATUS: begin
               s_next.rdata[`BDC_POS_MON_BELOW] = s_reg.monitor_below_status;
            end
            default: begin
            end
         endcase
      end
      s_next.ana.det_on = det_on;
      s_next.ana.det_continuous = det_on && !sampled;
      s_next.ana.sample_strobe = sampled && tick;
      s_next.ana.reset_threshold_select = s_next.reset_threshold_select;
      s_next.ana.monitor_offset_select = s_next.monitor_offset_select;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign reg_rdata = s_reg.rdata;
   assign analog_ctrl = s_reg.ana;
   // stall only while awake; a sleeping core has nothing to hold
   assign wake_hold = s_reg.loaded && !deep_sleep &&
                      (s_reg.active_mode == BDC_MODE_CONT_STALL) && !det_ready;
   assign monitor_irq = s_reg.monitor_irq_enable && s_reg.monitor_irq_flag;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // sampled rst_b keeps the release edge itself out: the flops still reset there
   a_fuse_active_load: assert property (
      rst_b && !s_reg.loaded |=> s_reg.active_mode == $past(detector_config_fuse.active_mode))
      else $error("active mode not loaded from fuse");
   a_fuse_sleep_load: assert property (
      rst_b && !s_reg.loaded |=> s_reg.sleep_mode == $past(detector_config_fuse.sleep_mode))
      else $error("sleep mode not loaded from fuse");
   a_active_held: assert property (
      s_reg.loaded |=> $stable(s_reg.active_mode))
      else $error("active mode changed after load");
   a_sleep_mode_used: assert property (
      s_reg.loaded && deep_sleep && s_reg.sleep_mode == 2'h0 |=> !analog_ctrl.det_on)
      else $error("detector on while sleep mode disabled");
   a_wake_mode_used: assert property (
      s_reg.loaded && !deep_sleep && s_reg.active_mode == BDC_MODE_SAMPLED
      |=> analog_ctrl.det_on && !analog_ctrl.det_continuous)
      else $error("awake mode not active setting");
   a_prot_no_key: assert property (
      reg_wr && reg_addr == `BDC_OFS_MODE_CONTROL && s_reg.key_cnt == 3'h0 &&
      !prot_key_written && s_reg.loaded |=> $stable(s_reg.sleep_mode) &&
      $stable(s_reg.sample_rate_select))
      else $error("protected bits changed without key");
   a_prot_with_key: assert property (
      prot_key_written ##1 !reg_wr ##1 reg_wr && reg_addr == `BDC_OFS_MODE_CONTROL
      |=> s_reg.sleep_mode == $past(reg_wdata[1:0]))
      else $error("keyed write to sleep mode lost");
   a_flag_off_clear: assert property (
      s_reg.loaded && !det_on |=> !s_reg.monitor_irq_flag)
      else $error("flag stayed set with detector off");
   a_flag_clear_w1: assert property (
      reg_wr && reg_addr == `BDC_OFS_INTERRUPT_FLAGS && reg_wdata[0] &&
      mon_below_in == s_reg.monitor_below_status |=> !s_reg.monitor_irq_flag)
      else $error("write one did not clear flag");
   a_irq_holds: assert property (
      monitor_irq && det_on && !(reg_wr && (reg_addr == `BDC_OFS_INTERRUPT_FLAGS ||
      reg_addr == `BDC_OFS_INTERRUPT_CONTROL)) |=> monitor_irq)
      else $error("irq dropped while flag not cleared");
   a_status_follow: assert property (
      det_on && !sampled && s_reg.loaded |=> s_reg.monitor_below_status == $past(mon_below_in))
      else $error("status not tracking comparator");
   a_fall_sets: assert property (
      det_on && !sampled && s_reg.monitor_trigger_select == `BDC_TRIG_FALL &&
      !s_reg.monitor_below_status && mon_below_in |=> s_reg.monitor_irq_flag)
      else $error("falling crossing did not set flag");
   a_strobe_only_sampled: assert property (
      analog_ctrl.sample_strobe |-> $past(sampled))
      else $error("sample strobe outside sampled mode");

   c_keyed_write: cover property (
      prot_key_written ##[1:4] reg_wr && reg_addr == `BDC_OFS_MODE_CONTROL);
   c_flag_irq: cover property (monitor_irq ##[1:20] !monitor_irq);
   c_sleep_sampled: cover property (deep_sleep && sampled ##[1:50] analog_ctrl.sample_strobe);
   c_wake_hold: cover property (wake_hold);

endmodule

/* File: verilog/bdc_sample_timer.sv */
`timescale 1ns/1ps
`include "bdc_params.svh"

module bdc_sample_timer
   import bdc_pkg::*;
#(
   parameter int PERIOD_1K = `BDC_CYC_1K,
   parameter int DIV_125 = `BDC_DIV_125
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic restart,
   input wire logic rate_125,
   output logic tick
);
   localparam int CW = $clog2(PERIOD_1K + 1);
   localparam int DW = $clog2(DIV_125 + 1);

   // refused at elaboration: the half-period restart needs room to count
   if (PERIOD_1K < 4 || DIV_125 < 2) begin : g_bad_timing
      $error("bdc_sample_timer: period or divider too small");
   end

   typedef struct packed {
      logic [CW-1:0] pre;
      logic [DW-1:0] div;
      logic tick;
   } bdc_tmr_t;

   bdc_tmr_t s_reg;
   bdc_tmr_t s_next;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (restart) begin
         // half period: first sample after a resync lands early, never late
         s_next.pre = CW'(PERIOD_1K / 2);
         s_next.div = '0;
      end else if (s_reg.pre == '0) begin
         s_next.pre = CW'(PERIOD_1K - 1);
         if (rate_125) begin
            if (s_reg.div == DW'(DIV_125 - 1)) begin
               s_next.div = '0;
               s_next.tick = 1'b1;
            end else begin
               s_next.div = s_reg.div + DW'(1);
            end
         end else begin
            s_next.tick = 1'b1;
         end
      end else begin
         s_next.pre = s_reg.pre - CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

endmodule
